// [hdl/key_exchange_pkg.sv]
package key_exchange_pkg;

  // ****************************************
  // command header and key-use encodings
  // ****************************************
  localparam logic [2:0] CMD_TYPE_VIDEO_PIPE = 3'h3;
  localparam logic [1:0] PIPE_BITSTREAM_DECODE = 2'h2;
  localparam logic [2:0] GROUP_CRYPTO = 3'h6;
  localparam logic [7:0] SUB_OP_KEY_EXCHANGE = 8'h01;
  localparam logic [15:0] LEN_NO_INLINE = 16'h0000;
  localparam logic [15:0] LEN_INLINE_KEY = 16'h0003;
  localparam logic [15:0] SKIP_LAST = 16'h0001;
  localparam logic [1:0] KEY_LAST_IDX = 2'h3;
  localparam logic [1:0] USE_TERMINATE = 2'h0;
  localparam logic [1:0] USE_NEW_KEY = 2'h1;
  localparam logic [1:0] USE_FRESHNESS = 2'h2;
  localparam logic [1:0] USE_RESERVED = 2'h3;

  // ****************************************
  // key source codes
  // ****************************************
  localparam logic [1:0] SRC_BASE = 2'h0;
  localparam logic [1:0] SRC_SESSION = 2'h1;
  localparam logic [1:0] SRC_DERIVED = 2'h2;

  // ****************************************
  // register map and bus answers
  // ****************************************
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FRESH0 = 8'h08;
  localparam logic [7:0] REG_FRESH1 = 8'h0c;
  localparam logic [7:0] REG_FRESH2 = 8'h10;
  localparam logic [7:0] REG_FRESH3 = 8'h14;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_STRICT_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // cipher constants
  // ****************************************
  localparam logic [7:0] AES_POLY = 8'h1b;
  localparam logic [7:0] AES_AFFINE = 8'h63;
  localparam logic [7:0] AES_INV_AFFINE = 8'h05;
  localparam logic [7:0] AES_RCON_FIRST = 8'h01;
  localparam logic [3:0] AES_LAST_ROUND = 4'h9;
  localparam logic [7:0] INV_MIX [4] = '{8'h0e, 8'h0b, 8'h0d, 8'h09};

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [2:0] cmd_type;
    logic [1:0] pipe;
    logic [2:0] group;
    logic [7:0] sub_op;
    logic [15:0] dword_length_field;
  } cmd_header_s;

  typedef struct packed {
    logic [1:0] key_use;
    logic [29:0] mbz;
  } key_use_dword_s;

  typedef struct packed {
    logic [7:0] rsvd_hi;
    logic [7:0] rejected;
    logic [7:0] accepted;
    logic [1:0] rsvd_lo;
    logic [1:0] last_use;
    logic last_rejected;
    logic busy;
    logic [1:0] key_src;
  } status_s;

  typedef enum logic [2:0] {ST_HDR, ST_USE, ST_KEY, ST_SKIP, ST_CRYPT} parse_state_e;

endpackage

// [hdl/key_cmd_decode.sv]
`timescale 1ns/1ns
module key_cmd_decode
  import key_exchange_pkg::*;
(
  // dword under inspection
  input wire logic [31:0] dword_i,
  // header view
  output logic hdr_match_o,
  output logic [15:0] dword_length_o,
  // key-use view
  output logic [1:0] key_use_o,
  output logic mbz_zero_o
);

  cmd_header_s hdr;
  key_use_dword_s use_dw;

  assign hdr = cmd_header_s'(dword_i);
  assign use_dw = key_use_dword_s'(dword_i);
  assign hdr_match_o = (hdr.cmd_type == CMD_TYPE_VIDEO_PIPE)
    && (hdr.pipe == PIPE_BITSTREAM_DECODE)
    && (hdr.group == GROUP_CRYPTO)
    && (hdr.sub_op == SUB_OP_KEY_EXCHANGE);
  assign dword_length_o = hdr.dword_length_field;
  assign key_use_o = use_dw.key_use;
  assign mbz_zero_o = (use_dw.mbz == 30'h0);

endmodule

// [hdl/aes128_ecb_dec.sv]
`timescale 1ns/1ns
module aes128_ecb_dec
  import key_exchange_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // request
  input wire logic start_i,
  input wire logic [127:0] key_i,
  input wire logic [127:0] data_i,
  // answer
  output logic busy_o,
  output logic done_o,
  output logic [127:0] data_o
);

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = {x[6:0], 1'b0} ^ (x[7] ? AES_POLY : 8'h00);
    end
    return p;
  endfunction

  // x^254 keeps the s-box free of a lookup table, at the cost of logic depth
  function automatic logic [7:0] ginv(input logic [7:0] a);
    logic [7:0] r;
    logic [7:0] p;
    r = AES_RCON_FIRST;
    p = a;
    for (int i = 1; i < 8; i++) begin
      p = gmul(p, p);
      r = gmul(r, p);
    end
    return r;
  endfunction

  function automatic logic [7:0] rotl(input logic [7:0] x, input int n);
    logic [15:0] t;
    t = {x, x} << n;
    return t[15:8];
  endfunction

  function automatic logic [7:0] sbox(input logic [7:0] a);
    logic [7:0] i;
    i = ginv(a);
    return i ^ rotl(i, 1) ^ rotl(i, 2) ^ rotl(i, 3) ^ rotl(i, 4) ^ AES_AFFINE;
  endfunction

  function automatic logic [7:0] isbox(input logic [7:0] a);
    return ginv(rotl(a, 1) ^ rotl(a, 3) ^ rotl(a, 6) ^ AES_INV_AFFINE);
  endfunction

  function automatic logic [31:0] subrot(input logic [31:0] w, input logic [7:0] rc);
    return {sbox(w[23:16]) ^ rc, sbox(w[15:8]), sbox(w[7:0]), sbox(w[31:24])};
  endfunction

  function automatic logic [127:0] next_key(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w2;
    w0 = k[127:96] ^ subrot(k[31:0], rc);
    w1 = k[95:64] ^ w0;
    w2 = k[63:32] ^ w1;
    return {w0, w1, w2, k[31:0] ^ w2};
  endfunction

  function automatic logic [127:0] prev_key(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] p3;
    p3 = k[31:0] ^ k[63:32];
    return {k[127:96] ^ subrot(p3, rc), k[95:64] ^ k[127:96], k[63:32] ^ k[95:64], p3};
  endfunction

  function automatic logic [127:0] inv_round(input logic [127:0] st, input logic [127:0] rk,
                                             input logic mix);
    logic [127:0] s;
    logic [127:0] m;
    s = 128'h0;
    m = 128'h0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        s[127 - 8 * (4 * c + r) -: 8] = isbox(st[127 - 8 * (4 * ((c + 4 - r) % 4) + r) -: 8]);
      end
    end
    s = s ^ rk;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        for (int j = 0; j < 4; j++) begin
          m[127 - 8 * (4 * c + r) -: 8] = m[127 - 8 * (4 * c + r) -: 8]
            ^ gmul(s[127 - 8 * (4 * c + (r + j) % 4) -: 8], INV_MIX[j]);
        end
      end
    end
    return mix ? m : s;
  endfunction

  logic busy_q;
  logic expand_q;
  logic done_q;
  logic [3:0] round_q;
  logic [7:0] rcon_q;
  logic [127:0] rk_q;
  logic [127:0] st_q;
  logic [127:0] rk_next;
  logic [127:0] rk_prev;
  logic last_expand;
  logic last_dec;

  assign rk_next = next_key(rk_q, rcon_q);
  assign rk_prev = prev_key(rk_q, rcon_q);
  assign last_expand = expand_q && (round_q == AES_LAST_ROUND);
  assign last_dec = busy_q && !expand_q && (round_q == 4'h0);

  // forward schedule first, then the rounds walk the schedule back down
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_q <= 1'b0;
      expand_q <= 1'b0;
      done_q <= 1'b0;
      round_q <= 4'h0;
      rcon_q <= 8'h00;
      rk_q <= 128'h0;
      st_q <= 128'h0;
    end else begin
      done_q <= last_dec;
      if (start_i && !busy_q) begin
        busy_q <= 1'b1;
        expand_q <= 1'b1;
        round_q <= 4'h0;
        rcon_q <= AES_RCON_FIRST;
        rk_q <= key_i;
        st_q <= data_i;
      end else if (expand_q) begin
        rk_q <= rk_next;
        rcon_q <= last_expand ? rcon_q : gmul(rcon_q, 8'h02);
        round_q <= last_expand ? AES_LAST_ROUND : round_q + 4'h1;
        expand_q <= !last_expand;
        if (last_expand) st_q <= st_q ^ rk_next;
      end else if (busy_q) begin
        rk_q <= rk_prev;
        rcon_q <= rcon_q[0] ? (((rcon_q ^ AES_POLY) >> 1) | 8'h80) : (rcon_q >> 1);
        st_q <= inv_round(st_q, rk_prev, round_q != 4'h0);
        round_q <= round_q - 4'h1;
        busy_q <= !last_dec;
      end
    end
  end

  assign busy_o = busy_q;
  assign done_o = done_q;
  assign data_o = st_q;

  a_dec_latency: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (start_i && !busy_q) |-> ##21 done_q)
    else $error("decrypt did not finish in 21 cycles");
  a_done_single: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    done_q |=> !done_q && !busy_q)
    else $error("done held or busy after done");

endmodule

// [hdl/key_exchange_state_command.sv]
`timescale 1ns/1ns
module key_exchange_state_command
  import key_exchange_pkg::*;
#(
  parameter logic [127:0] BASE_KEY = 128'h0,
  parameter logic [127:0] UNWRAP_KEY = 128'h0
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // command stream
  input wire logic cmd_valid_i,
  input wire logic [31:0] cmd_dword_i,
  output logic cmd_ready_o,
  // key state
  output logic [127:0] key_o,
  output logic [1:0] key_src_o,
  output logic key_update_o,
  output logic cmd_done_o,
  output logic cmd_reject_o,
  // axi4-lite write
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);

  // ****************************************
  // command parser
  // ****************************************
  parse_state_e state_q;
  parse_state_e state_d;
  logic cmd_ready_q;
  logic hdr_ok_q;
  logic [15:0] len_q;
  logic [15:0] skip_q;
  logic [1:0] kidx_q;
  logic [127:0] key_buf_q;
  logic [127:0] key_q;
  logic [127:0] session_q;
  logic [1:0] src_q;
  logic upd_q;
  logic done_q;
  logic rej_q;
  logic last_rej_q;
  logic [1:0] last_use_q;
  logic [7:0] acc_cnt_q;
  logic [7:0] rej_cnt_q;
  logic [1:0] ctrl_q;
  logic [127:0] fresh_ctr_q;
  logic [127:0] fresh_snap_q;

  logic take;
  logic hdr_match;
  logic [15:0] dw_len;
  logic [1:0] key_use;
  logic mbz_zero;
  logic len_ok;
  logic use_legal;
  logic act_term;
  logic act_fresh;
  logic aes_start;
  logic fin;
  logic rej;
  logic adopt;
  logic aes_busy;
  logic aes_done;
  logic [127:0] aes_out;

  key_cmd_decode u_decode (
    .dword_i(cmd_dword_i),
    .hdr_match_o(hdr_match),
    .dword_length_o(dw_len),
    .key_use_o(key_use),
    .mbz_zero_o(mbz_zero)
  );

  aes128_ecb_dec u_unwrap (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .start_i(aes_start),
    .key_i(UNWRAP_KEY),
    .data_i(key_buf_q),
    .busy_o(aes_busy),
    .done_o(aes_done),
    .data_o(aes_out)
  );

  assign take = cmd_valid_i && cmd_ready_q;
  assign len_ok = (key_use == USE_RESERVED) ? 1'b1 :
    (key_use == USE_NEW_KEY) ? (len_q == LEN_INLINE_KEY) : (len_q == LEN_NO_INLINE);
  // strict mode also refuses nonzero reserved bits in the key-use dword
  assign use_legal = hdr_ok_q && len_ok && (mbz_zero || !ctrl_q[CTRL_STRICT_BIT]);
  assign adopt = (state_q == ST_CRYPT) && aes_done;

  always_comb begin
    state_d = state_q;
    act_term = 1'b0;
    act_fresh = 1'b0;
    aes_start = 1'b0;
    fin = 1'b0;
    rej = 1'b0;
    case (state_q)
      ST_HDR: begin
        if (take) state_d = ST_USE;
      end
      ST_USE: begin
        if (take) begin
          if (use_legal && key_use == USE_NEW_KEY) begin
            state_d = ST_KEY;
          end else begin
            act_term = use_legal && (key_use == USE_TERMINATE);
            act_fresh = use_legal && (key_use == USE_FRESHNESS);
            rej = !use_legal;
            fin = (len_q == LEN_NO_INLINE);
            // trailing dwords of any other action are drained unread
            state_d = fin ? ST_HDR : ST_SKIP;
          end
        end
      end
      ST_KEY: begin
        if (take && kidx_q == KEY_LAST_IDX) begin
          aes_start = 1'b1;
          state_d = ST_CRYPT;
        end
      end
      ST_SKIP: begin
        if (take && skip_q == SKIP_LAST) begin
          fin = 1'b1;
          state_d = ST_HDR;
        end
      end
      ST_CRYPT: begin
        if (aes_done) begin
          fin = 1'b1;
          state_d = ST_HDR;
        end
      end
      default: state_d = ST_HDR;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_HDR;
      cmd_ready_q <= 1'b0;
      hdr_ok_q <= 1'b0;
      len_q <= 16'h0000;
      skip_q <= 16'h0000;
      kidx_q <= 2'h0;
      key_buf_q <= 128'h0;
    end else begin
      state_q <= state_d;
      // stall the stream while the cipher works
      cmd_ready_q <= ctrl_q[CTRL_ENABLE_BIT] && (state_d != ST_CRYPT);
      if (take && state_q == ST_HDR) begin
        hdr_ok_q <= hdr_match;
        len_q <= dw_len;
      end
      if (take && state_q == ST_USE) skip_q <= len_q;
      if (take && state_q == ST_SKIP) skip_q <= skip_q - 16'h0001;
      if (take && state_q == ST_USE) kidx_q <= 2'h0;
      if (take && state_q == ST_KEY) begin
        key_buf_q[32 * kidx_q +: 32] <= cmd_dword_i;
        kidx_q <= kidx_q + 2'h1;
      end
    end
  end

  // ****************************************
  // key state
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      key_q <= BASE_KEY;
      session_q <= BASE_KEY;
      src_q <= SRC_BASE;
    end else if (act_term) begin
      key_q <= BASE_KEY;
      session_q <= BASE_KEY;
      src_q <= SRC_BASE;
    end else if (act_fresh) begin
      key_q <= session_q ^ fresh_snap_q;
      src_q <= SRC_DERIVED;
    end else if (adopt) begin
      key_q <= aes_out;
      session_q <= aes_out;
      src_q <= SRC_SESSION;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      upd_q <= 1'b0;
      done_q <= 1'b0;
      rej_q <= 1'b0;
      last_rej_q <= 1'b0;
      last_use_q <= USE_TERMINATE;
      acc_cnt_q <= 8'h00;
      rej_cnt_q <= 8'h00;
    end else begin
      upd_q <= act_term || act_fresh || adopt;
      done_q <= fin;
      rej_q <= rej;
      if (take && state_q == ST_USE) begin
        last_use_q <= key_use;
        last_rej_q <= rej;
      end
      if (fin && !rej && !(state_q == ST_SKIP && last_rej_q)) acc_cnt_q <= acc_cnt_q + 8'h01;
      if (rej) rej_cnt_q <= rej_cnt_q + 8'h01;
    end
  end

  // ****************************************
  // register slave
  // ****************************************
  logic aw_have_q;
  logic w_have_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] aw_off_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_wr;
  logic aw_have_d;
  logic w_have_d;
  logic bvalid_d;
  logic rvalid_d;
  logic [7:0] ar_off;
  logic wr_ctrl;
  logic rd_hit;
  logic [31:0] rd_word;
  status_s status;

  assign aw_take = s_axi_awvalid_i && awready_q;
  assign w_take = s_axi_wvalid_i && wready_q;
  assign ar_take = s_axi_arvalid_i && arready_q;
  assign do_wr = aw_have_q && w_have_q && !bvalid_q;
  assign aw_have_d = aw_take || (aw_have_q && !do_wr);
  assign w_have_d = w_take || (w_have_q && !do_wr);
  assign bvalid_d = do_wr || (bvalid_q && !s_axi_bready_i);
  assign rvalid_d = ar_take || (rvalid_q && !s_axi_rready_i);
  assign ar_off = {s_axi_araddr_i[7:2], 2'b00};
  assign wr_ctrl = do_wr && (aw_off_q == REG_CTRL) && wstrb_q[0];
  assign status = '{rsvd_hi: 8'h00, rejected: rej_cnt_q, accepted: acc_cnt_q, rsvd_lo: 2'h0,
    last_use: last_use_q, last_rejected: last_rej_q, busy: (state_q != ST_HDR) || aes_busy,
    key_src: src_q};
  assign rd_hit = (ar_off == REG_CTRL) || (ar_off == REG_STATUS) || (ar_off == REG_FRESH0)
    || (ar_off == REG_FRESH1) || (ar_off == REG_FRESH2) || (ar_off == REG_FRESH3);
  // a read of the first freshness word latches the value the derivation will use
  assign rd_word = (ar_off == REG_CTRL) ? {30'h0, ctrl_q} :
    (ar_off == REG_STATUS) ? 32'(status) :
    (ar_off == REG_FRESH0) ? fresh_ctr_q[31:0] :
    (ar_off == REG_FRESH1) ? fresh_snap_q[63:32] :
    (ar_off == REG_FRESH2) ? fresh_snap_q[95:64] :
    (ar_off == REG_FRESH3) ? fresh_snap_q[127:96] : 32'h0;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      aw_off_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      ctrl_q <= CTRL_RESET;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awready_q <= !aw_have_d && !bvalid_d;
      wready_q <= !w_have_d && !bvalid_d;
      bvalid_q <= bvalid_d;
      if (aw_take) aw_off_q <= {s_axi_awaddr_i[7:2], 2'b00};
      if (w_take) wdata_q <= s_axi_wdata_i;
      if (w_take) wstrb_q <= s_axi_wstrb_i;
      if (do_wr) bresp_q <= (aw_off_q == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
      if (wr_ctrl) ctrl_q <= wdata_q[1:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0;
      fresh_ctr_q <= 128'h0;
      fresh_snap_q <= 128'h0;
    end else begin
      arready_q <= !rvalid_d;
      rvalid_q <= rvalid_d;
      fresh_ctr_q <= fresh_ctr_q + 128'h1;
      if (ar_take) rdata_q <= rd_word;
      if (ar_take) rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      if (ar_take && ar_off == REG_FRESH0) fresh_snap_q <= fresh_ctr_q;
    end
  end

  assign cmd_ready_o = cmd_ready_q;
  assign key_o = key_q;
  assign key_src_o = src_q;
  assign key_update_o = upd_q;
  assign cmd_done_o = done_q;
  assign cmd_reject_o = rej_q;
  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign s_axi_rvalid_o = rvalid_q;

  // ****************************************
  // checks
  // ****************************************
  a_term_base: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    act_term |=> (key_o == BASE_KEY) && (key_src_o == SRC_BASE) && key_update_o)
    else $error("terminate did not restore base key");
  a_fresh_derive: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    act_fresh |=> key_o == ($past(session_q) ^ $past(fresh_snap_q)))
    else $error("derived key mismatch");
  a_adopt_key: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    adopt |=> (key_o == $past(aes_out)) && (key_src_o == SRC_SESSION))
    else $error("decrypted key not adopted");
  a_crypt_stall: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (state_q == ST_CRYPT) |-> !cmd_ready_o)
    else $error("stream accepted during decrypt");
  a_reserved_hold: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (take && state_q == ST_USE && key_use == USE_RESERVED) |=> $stable(key_o) ##1 $stable(key_o))
    else $error("reserved action changed key");
  a_foreign_hdr: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (take && state_q == ST_USE && !hdr_ok_q) |=> cmd_reject_o && !key_update_o)
    else $error("foreign header not rejected");
  a_len_check: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (take && state_q == ST_USE && hdr_ok_q && key_use == USE_NEW_KEY && len_q != LEN_INLINE_KEY)
    |=> cmd_reject_o)
    else $error("bad length accepted");
  a_bvalid_hold: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (s_axi_bvalid_o && !s_axi_bready_i) |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");

endmodule

// [verification/cmd_streamer.sv]
`timescale 1ns/1ns
module cmd_streamer (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // command stream
  input wire logic cmd_ready_i,
  output logic cmd_valid_o,
  output logic [31:0] cmd_dword_o
);
  // ****************
  // issuer queue
  // ****************
  logic [31:0] fifo_q[$];
  logic hold;
  logic go;
  // a dword stays put until taken; idle gaps show a changing pattern
  always @(posedge sys_clk_i) begin
    hold = cmd_valid_o && !cmd_ready_i;
    if (!arst_n_i) begin
      cmd_valid_o <= 1'b0;
      cmd_dword_o <= 32'h0;
    end else begin
      if (cmd_valid_o && cmd_ready_i) begin
        fifo_q.delete(0);
      end
      if (!hold) begin
        go = fifo_q.size() != 0 && $urandom_range(3) != 0;
        cmd_valid_o <= go;
        cmd_dword_o <= go ? fifo_q[0] : ~cmd_dword_o;
      end
    end
  end
endmodule

// [verification/key_exchange_state_command_tb.sv]
`timescale 1ns/1ns
module key_exchange_state_command_tb import key_exchange_pkg::*; ;
  typedef struct packed {
    logic rej;
    logic upd;
    logic chk;
    logic [1:0] src;
    logic [127:0] key;
  } note_s;
  localparam logic [127:0] BK = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
  localparam logic [31:0] U_TERM = {USE_TERMINATE, 30'h0};
  localparam note_s N_BASE = '{1'b0, 1'b1, 1'b1, SRC_BASE, BK};
  localparam note_s N_REJ = '{1'b1, 1'b0, 1'b0, SRC_SESSION, BK};
  logic clk = 0, rst_n = 0, cv, rdy, upd, done, rej;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, cd, rdata;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, awr, wr, bv, arr, rv;
  logic [1:0] bresp, rresp, src;
  logic [127:0] key, snap;
  int fails = 0, n_compared = 0;
  note_s notes[$];
  note_s n;
  key_exchange_state_command #(.BASE_KEY(BK), .UNWRAP_KEY(~BK)) u_key_exchange_state_command (
    .sys_clk_i(clk), .arst_n_i(rst_n), .cmd_valid_i(cv), .cmd_dword_i(cd), .cmd_ready_o(rdy),
    .key_o(key), .key_src_o(src), .key_update_o(upd), .cmd_done_o(done), .cmd_reject_o(rej),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rry));
  cmd_streamer u_cmd_streamer (.sys_clk_i(clk), .arst_n_i(rst_n), .cmd_ready_i(rdy),
    .cmd_valid_o(cv), .cmd_dword_o(cd));
  initial forever #10 clk = ~clk;
  // ****************
  // shared tasks
  // ****************
  task automatic wrap_up();
    if (fails == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic compare(input logic [127:0] got, input logic [127:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    {awv, wv, bry} <= 3'b111;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (awr && !ad) awv <= 0;
      ad = ad | awr;
      if (wr && !wd) wv <= 0;
      wd = wd | wr;
    end
    while (bv !== 1'b1) @(posedge clk);
    bry <= 0;
    compare(bresp, er);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    {arv, rry} <= 2'b11;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 0;
    do @(posedge clk); while (rv !== 1'b1);
    rry <= 0;
    d = rdata;
    compare(rresp, er);
  endtask
  function automatic logic [31:0] hdr(input logic [15:0] len);
    cmd_header_s h;
    h = '{CMD_TYPE_VIDEO_PIPE, PIPE_BITSTREAM_DECODE, GROUP_CRYPTO, SUB_OP_KEY_EXCHANGE, len};
    return h;
  endfunction
  task automatic send(input logic [31:0] h, input logic [31:0] u, input int k, input note_s e);
    u_cmd_streamer.fifo_q.push_back(h);
    u_cmd_streamer.fifo_q.push_back(u);
    repeat (k) u_cmd_streamer.fifo_q.push_back($urandom);
    notes.push_back(e);
    while (notes.size() != 0) @(posedge clk);
  endtask
  // one note per finished or refused command
  always @(posedge clk) begin
    if (rst_n && (done | rej) === 1'b1) begin
      if (notes.size() == 0) compare(1'b1, 1'b0);
      else begin
        n = notes.pop_front();
        compare(rej, n.rej);
        compare(upd, n.upd);
        compare(src, n.src);
        if (n.chk) compare(key, n.key);
      end
    end
  end
  initial begin
    #400000;
    fails++;
    wrap_up();
  end
  initial begin
    logic [31:0] d;
    int sh[4];
    sh = '{29, 27, 24, 16};
    void'($urandom(14187));
    repeat (3) @(posedge clk);
    rst_n <= 1;
    axi_rd(REG_CTRL, RESP_OKAY, d);
    compare(d, 32'h1);
    axi_wr(REG_CTRL, 32'h3, RESP_OKAY);
    axi_wr(REG_FRESH0, 32'h0, RESP_SLVERR);
    axi_rd(8'h40, RESP_SLVERR, d);
    compare(d, 32'h0);
    send(hdr(LEN_NO_INLINE), U_TERM, 0, N_BASE);
    send(hdr(LEN_INLINE_KEY), {USE_NEW_KEY, 30'h0}, 4, '{0, 1, 0, SRC_SESSION, BK});
    send(hdr(LEN_NO_INLINE), {USE_RESERVED, 30'h0}, 0, '{0, 0, 0, SRC_SESSION, BK});
    foreach (sh[i]) send(hdr(LEN_NO_INLINE) ^ (32'h1 << sh[i]), U_TERM, 0, N_REJ);
    send(hdr(LEN_NO_INLINE), {USE_NEW_KEY, 30'h0}, 0, N_REJ);
    send(hdr(LEN_NO_INLINE), {USE_TERMINATE, 30'h1}, 0, N_REJ);
    send(hdr(LEN_NO_INLINE), U_TERM, 0, N_BASE);
    for (int i = 0; i < 4; i++) begin
      axi_rd(REG_FRESH0 + 8'(4 * i), RESP_OKAY, d);
      snap[32*i +: 32] = d;
    end
    send(hdr(LEN_NO_INLINE), {USE_FRESHNESS, 30'h0}, 0,
      '{0, 1, 1, SRC_DERIVED, BK ^ snap});
    send(hdr(LEN_NO_INLINE), U_TERM, 0, N_BASE);
    // six taken, six refused, idle, last action terminate on the base key
    axi_rd(REG_STATUS, RESP_OKAY, d);
    compare(d, 32'h00060600);
    wrap_up();
  end
endmodule
